// ---- hdl/adcc_defines.svh ----
// register indices, field positions, reset values and timing counts of the converter control
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH
// register indices; byte address is four times the index
`define ADCC_IDX_TRIG 3'h3
`define ADCC_IDX_RES_LO 3'h4
`define ADCC_IDX_RES_HI 3'h5
`define ADCC_IDX_CSRA 3'h6
`define ADCC_IDX_MUX 3'h7
// control/status A fields
`define ADCC_CSRA_EN 7
`define ADCC_CSRA_START 6
`define ADCC_CSRA_AUTO 5
`define ADCC_CSRA_FLAG 4
`define ADCC_CSRA_IE 3
// input and reference select fields
`define ADCC_MUX_REF1 7
`define ADCC_MUX_REF0 6
`define ADCC_MUX_ALIGN 5
`define ADCC_MUX_REF2 4
// trigger register field
`define ADCC_TRIG_SETTLED 3
`define ADCC_REG_RESET 8'h00
// conversion lengths in converter clock cycles
`define ADCC_CONV_SHORT 5'h0d
`define ADCC_CONV_LONG 5'h19
// reference settling time
`define ADCC_CLK_NS 10
`define ADCC_SETTLE_NS 1000000
`endif

// ---- hdl/adcc_pkg.sv ----
// types shared by the converter control modules
package adcc_pkg;
    typedef enum logic [2:0] {
        ADCC_REF_SUPPLY, ADCC_REF_EXT, ADCC_REF_1V1, ADCC_REF_RSVD,
        ADCC_REF_2V56, ADCC_REF_2V56_CAP
    } adcc_ref_type;
    typedef struct packed {
        logic en, busy, auto_en, flag, ie;
        logic [2:0] div, ref_sel;
        logic align;
        logic [3:0] chan;
        logic [2:0] trig_src;
        logic trig_prev, long_next, long_cur;
        logic [4:0] cnt;
        adcc_ref_type act_ref;
        logic [3:0] act_chan;
        logic gain_20x, diff_mode, temp_on;
        logic [16:0] settle_cnt;
        logic settled, irq, pready, pslverr;
        logic [31:0] prdata;
    } adcc_ctrl_type;
    typedef struct packed {
        logic [6:0] cnt;
        logic tick;
    } adcc_presc_type;
    typedef struct packed {
        logic [9:0] res;
        logic locked;
    } adcc_res_type;
endpackage

// ---- hdl/adcc_conv_if.sv ----
// signals between the control core, the prescaler and the result pair
`timescale 1ns/1ps
`default_nettype none
interface adcc_conv_if;
    logic run, tick, load, align, rd_low, rd_high, rd_low_pend, locked;
    logic [2:0] div;
    logic [9:0] data;
    logic [7:0] lo_byte, hi_byte;
    modport ctrl(output run, div, load, data, align, rd_low, rd_high, rd_low_pend,
                 input tick, lo_byte, hi_byte, locked);
    modport presc(input run, div, output tick);
    modport res(input load, data, align, rd_low, rd_high, rd_low_pend,
                output lo_byte, hi_byte, locked);
endinterface
`default_nettype wire

// ---- hdl/adcc_prescaler.sv ----
// converter clock prescaler: one-cycle tick every 2 to 128 system clocks
`timescale 1ns/1ps
`default_nettype none
module adcc_prescaler (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link to the control core
    adcc_conv_if.presc cif
);
    import adcc_pkg::*;
    adcc_presc_type st_q, st_d;
    logic [6:0] mask;
    // codes 0 and 1 both divide by two, each higher code doubles
    always_comb begin
        st_d = st_q;
        mask = (cif.div <= 3'h1) ? 7'h01 : 7'((8'h01 << cif.div) - 8'h01); // see (RQ19)
        st_d.cnt = cif.run ? st_q.cnt + 7'h01 : 7'h00;
        st_d.tick = cif.run && ((st_q.cnt & mask) == mask);
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign cif.tick = st_q.tick;
    // with divide-by-two the tick alternates while the setting stands
    fast_div_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ19)
        st_q.tick && cif.run && cif.div <= 3'h1 && $stable(cif.div) && $past(cif.run)
        |=> !st_q.tick || !cif.run)
        else $error("prescaler ticked twice in a row at divide by two");
endmodule
`default_nettype wire

// ---- hdl/adcc_result.sv ----
// result pair: holds the last result and the low-then-high read lock, and applies the alignment on read
`timescale 1ns/1ps
`default_nettype none
module adcc_result (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link to the control core
    adcc_conv_if.res cif
);
    import adcc_pkg::*;
    adcc_res_type st_q, st_d;
    // a pending low read also blocks the load so the pair read stays coherent
    always_comb begin
        st_d = st_q;
        if (cif.load && !st_q.locked && !cif.rd_low_pend) begin
            st_d.res = cif.data; // see (RQ23)
        end
        if (cif.rd_low) begin
            st_d.locked = 1'b1; // see (RQ20)
        end else if (cif.rd_high) begin
            st_d.locked = 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    // alignment acts on the read path, so a change shows at once
    assign cif.lo_byte = cif.align ? {st_q.res[1:0], 6'h00} : st_q.res[7:0]; // see (RQ4) (RQ21)
    assign cif.hi_byte = cif.align ? st_q.res[9:2] : {6'h00, st_q.res[9:8]}; // see (RQ22)
    assign cif.locked = st_q.locked;
    lock_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ23)
        st_q.locked && !cif.rd_high |=> $stable(st_q.res))
        else $error("result changed while the pair was locked");
endmodule
`default_nettype wire

// ---- hdl/adcc_top.sv ----
// converter control core: APB registers, sequencing, input/reference select and result pair
// What this block does
// (RQ1) three reference bits pick supply, pin, 1.1V or 2.56V; 011 reserved
// (RQ2) reference change during conversion applies only after completion
// (RQ3) any reference change makes the next conversion 25 cycles
// (RQ4) alignment bit picks left or right result, effective immediately
// (RQ5) codes 0000-0011 select four single-ended inputs
// (RQ6) codes 0100-1011 select differential pairs; odd codes gain 20x
// (RQ7) codes 0100,0101,1000,1001 tie both inputs to one pin for offset
// (RQ8) 1100 bandgap, 1101 ground, 1110 unused, 1111 temperature sensor on
// (RQ9) channel change during conversion applies only after completion
// (RQ10) internal reference needs 1ms settling with converter enabled
// (RQ11) enable bit powers converter; clearing it aborts a conversion
// (RQ12) start bit write begins conversion; free-running then repeats itself
// (RQ13) first conversion after enabling takes 25 cycles, others 13
// (RQ14) start bit reads one while busy; writing zero does nothing
// (RQ15) auto-trigger starts on rising edge of the selected trigger
// (RQ16) done flag sets when conversion ends and result is loaded
// (RQ17) done flag clears on interrupt vector or writing one
// (RQ18) interrupt asserted while flag, enable and global enable all set
// (RQ19) prescaler divides system clock by 2 to 128
// (RQ20) low byte read locks the pair until high byte read
// (RQ21) left aligned: high byte bits 9-2, low byte bits 1-0 on top
// (RQ22) right aligned: low byte bits 7-0, high byte bits 9-8 at bottom
// (RQ23) result loads with flag set, held while the pair is locked
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.svh"
module adcc_top #(
    parameter int SETTLE_CYCLES = `ADCC_SETTLE_NS / `ADCC_CLK_NS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [4:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog core
    input wire logic [9:0] conv_data,
    output logic conv_on,
    output logic conv_busy,
    output adcc_pkg::adcc_ref_type ref_sel_eff,
    output logic [3:0] chan_eff,
    output logic gain_20x,
    output logic diff_mode,
    output logic temp_sensor_on,
    output logic ref_settled,
    // triggers and cpu interrupt
    input wire logic [7:0] trig_in,
    input wire logic gie,
    input wire logic irq_ack,
    output logic irq
);
    import adcc_pkg::*;

    // ==========================================================
    // submodules
    adcc_conv_if cif();
    adcc_prescaler u_presc (
        .mclk(mclk),
        .rst_n(rst_n),
        .cif(cif)
    );
    adcc_result u_res (
        .mclk(mclk),
        .rst_n(rst_n),
        .cif(cif)
    );

    // ==========================================================
    // decoders
    function automatic adcc_ref_type ref_decode(input logic [2:0] code);
        adcc_ref_type r;
        r = ADCC_REF_RSVD;
        // top bit is ignored when the low bits are 00 or 01
        casez (code)
            3'b?00: r = ADCC_REF_SUPPLY; // see (RQ1)
            3'b?01: r = ADCC_REF_EXT;
            3'b010: r = ADCC_REF_1V1;
            3'b011: r = ADCC_REF_RSVD;
            3'b110: r = ADCC_REF_2V56;
            3'b111: r = ADCC_REF_2V56_CAP;
            default: r = ADCC_REF_RSVD;
        endcase
        return r;
    endfunction

    adcc_ctrl_type st_q, st_d;
    logic acc, bus_done, mapped, wr, rd, rd_acc;
    logic [2:0] idx;
    logic [7:0] rdata;
    logic en_next, start_wr, trig_sel, trig_edge, done_now, start_req, internal;
    logic [4:0] last_cnt;

    // ==========================================================
    // bus decode: answer one cycle after the access phase begins
    always_comb begin
        idx = paddr[4:2];
        acc = psel && penable;
        bus_done = acc && st_q.pready;
        mapped = (paddr[1:0] == 2'h0) && (idx >= `ADCC_IDX_TRIG);
        wr = bus_done && pwrite && mapped;
        rd = bus_done && !pwrite && mapped;
        rd_acc = acc && !st_q.pready && !pwrite;
        rdata = `ADCC_REG_RESET;
        case (idx)
            `ADCC_IDX_TRIG: rdata = {4'h0, st_q.settled, st_q.trig_src};
            `ADCC_IDX_RES_LO: rdata = cif.lo_byte;
            `ADCC_IDX_RES_HI: rdata = cif.hi_byte;
            `ADCC_IDX_CSRA: rdata = {st_q.en, st_q.busy, st_q.auto_en, st_q.flag,
                                     st_q.ie, st_q.div}; // see (RQ14)
            `ADCC_IDX_MUX: rdata = {st_q.ref_sel[1:0], st_q.align, st_q.ref_sel[2],
                                    st_q.chan};
            default: rdata = `ADCC_REG_RESET;
        endcase
    end

    // link to prescaler and result pair
    assign cif.run = st_q.en;
    assign cif.div = st_q.div;
    assign cif.load = done_now;
    assign cif.data = conv_data;
    assign cif.align = st_q.align;
    assign cif.rd_low = rd && idx == `ADCC_IDX_RES_LO;
    assign cif.rd_high = rd && idx == `ADCC_IDX_RES_HI;
    assign cif.rd_low_pend = acc && !pwrite && idx == `ADCC_IDX_RES_LO;

    // ==========================================================
    // next state
    always_comb begin
        st_d = st_q;
        en_next = st_q.en;
        start_wr = 1'b0;
        // read data is captured before the completing edge
        st_d.pready = acc && !st_q.pready;
        st_d.pslverr = acc && !st_q.pready && !mapped;
        st_d.prdata = (rd_acc && mapped) ? {24'h000000, rdata} : 32'h00000000;
        // register writes
        if (wr) begin
            case (idx)
                `ADCC_IDX_TRIG: st_d.trig_src = pwdata[2:0];
                `ADCC_IDX_CSRA: begin
                    en_next = pwdata[`ADCC_CSRA_EN]; // see (RQ11)
                    start_wr = pwdata[`ADCC_CSRA_START]; // see (RQ12) (RQ14)
                    st_d.auto_en = pwdata[`ADCC_CSRA_AUTO];
                    st_d.ie = pwdata[`ADCC_CSRA_IE];
                    st_d.div = pwdata[2:0];
                end
                `ADCC_IDX_MUX: begin
                    st_d.ref_sel = {pwdata[`ADCC_MUX_REF2], pwdata[`ADCC_MUX_REF1],
                                    pwdata[`ADCC_MUX_REF0]};
                    st_d.align = pwdata[`ADCC_MUX_ALIGN]; // see (RQ4)
                    st_d.chan = pwdata[3:0];
                    if (st_d.ref_sel != st_q.ref_sel) begin
                        st_d.long_next = 1'b1; // see (RQ3)
                    end
                end
                default: st_d.trig_src = st_q.trig_src;
            endcase
        end
        st_d.en = en_next;
        // enabling, even in the same write as a start, lengthens the next conversion
        if (en_next && !st_q.en) begin
            st_d.long_next = 1'b1; // see (RQ13)
        end
        // trigger edge; source zero is free running and has no edge
        trig_sel = trig_in[st_q.trig_src];
        st_d.trig_prev = trig_sel;
        trig_edge = trig_sel && !st_q.trig_prev && st_q.trig_src != 3'h0; // see (RQ15)
        // conversion progress in converter clock ticks
        last_cnt = (st_q.long_cur ? `ADCC_CONV_LONG : `ADCC_CONV_SHORT) - 5'h01;
        done_now = st_q.busy && st_q.en && cif.tick && st_q.cnt == last_cnt; // see (RQ13)
        if (st_q.busy && cif.tick) begin
            st_d.cnt = st_q.cnt + 5'h01;
        end
        if (done_now) begin
            st_d.busy = 1'b0; // see (RQ14)
        end
        start_req = en_next && (start_wr || (st_q.auto_en && (trig_edge ||
                    (done_now && st_q.trig_src == 3'h0)))); // see (RQ12) (RQ15)
        if (!en_next) begin
            st_d.busy = 1'b0; // see (RQ11)
            st_d.cnt = 5'h00;
        end else if (start_req && (!st_q.busy || done_now)) begin
            st_d.busy = 1'b1;
            st_d.cnt = 5'h00;
            st_d.long_cur = st_d.long_next;
            st_d.long_next = 1'b0;
        end
        // selections follow the registers only between conversions
        if (!st_q.busy || done_now) begin
            st_d.act_ref = ref_decode(st_d.ref_sel); // see (RQ2)
            st_d.act_chan = st_d.chan; // see (RQ9) (RQ5)
            st_d.diff_mode = st_d.chan >= 4'h4 && st_d.chan <= 4'hb; // see (RQ6) (RQ7)
            st_d.gain_20x = st_d.diff_mode && st_d.chan[0]; // see (RQ6)
            st_d.temp_on = st_d.chan == 4'hf; // see (RQ8)
        end
        // flag: a completion in the same cycle as a clear wins
        if ((wr && idx == `ADCC_IDX_CSRA && pwdata[`ADCC_CSRA_FLAG]) || irq_ack) begin
            st_d.flag = 1'b0; // see (RQ17)
        end
        if (done_now) begin
            st_d.flag = 1'b1; // see (RQ16)
        end
        st_d.irq = st_d.flag && st_d.ie && gie; // see (RQ18)
        // settling of the internal reference; restarts on any switch
        internal = st_d.act_ref == ADCC_REF_1V1 || st_d.act_ref == ADCC_REF_2V56 ||
                   st_d.act_ref == ADCC_REF_2V56_CAP;
        if (!st_d.en || !internal || st_d.act_ref != st_q.act_ref) begin
            st_d.settle_cnt = 17'(SETTLE_CYCLES); // see (RQ10)
        end else if (st_q.settle_cnt != 17'h00000) begin
            st_d.settle_cnt = st_q.settle_cnt - 17'h00001;
        end
        st_d.settled = st_d.en && internal && st_d.settle_cnt == 17'h00000;
    end

    // ==========================================================
    // state register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.settle_cnt <= 17'(SETTLE_CYCLES);
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign conv_on = st_q.en;
    assign conv_busy = st_q.busy;
    assign ref_sel_eff = st_q.act_ref;
    assign chan_eff = st_q.act_chan;
    assign gain_20x = st_q.gain_20x;
    assign diff_mode = st_q.diff_mode;
    assign temp_sensor_on = st_q.temp_on;
    assign ref_settled = st_q.settled;
    assign irq = st_q.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_enable_rise;
        !st_q.en ##1 st_q.en;
    endsequence
    sequence s_idle_start;
        st_q.busy && $past(!st_q.busy);
    endsequence

    // a free-running restart may raise busy again at once, but with the count cleared
    flag_on_done_a: assert property (done_now |=> st_q.flag && (!st_q.busy || st_q.cnt == 5'h00)) // see (RQ16)
        else $error("completion did not set the flag");
    flag_clear_a: assert property (irq_ack && !done_now |=> !st_q.flag) // see (RQ17)
        else $error("vector did not clear the flag");
    irq_gate_a: assert property ($past(gie) && st_q.flag && st_q.ie |-> st_q.irq) // see (RQ18)
        else $error("interrupt missing with flag and enables set");
    abort_off_a: assert property (!st_q.en |-> !st_q.busy) // see (RQ11)
        else $error("busy while converter disabled");
    // a completion edge may load new selections even when the next conversion follows at once
    ref_hold_a: assert property (st_q.busy && $past(st_q.busy) && !$past(done_now)
        |-> $stable(st_q.act_ref))
        else $error("reference changed mid conversion"); // see (RQ2)
    chan_hold_a: assert property (st_q.busy && $past(st_q.busy) && !$past(done_now)
        |-> $stable(st_q.act_chan))
        else $error("channel changed mid conversion"); // see (RQ9)
    first_long_a: assert property (s_enable_rise ##0 s_idle_start |-> st_q.long_cur) // see (RQ13)
        else $error("first conversion after enable not long");
    busy_read_a: assert property (rd_acc && mapped && idx == `ADCC_IDX_CSRA // see (RQ14)
        |=> st_q.prdata[`ADCC_CSRA_START] == $past(st_q.busy))
        else $error("start bit does not read back busy");
    short_len_a: assert property (st_q.busy && !st_q.long_cur && st_q.cnt > 5'h0c |-> 1'b0)
        else $error("short conversion exceeded 13 cycles"); // see (RQ13)
endmodule
`default_nettype wire

// ---- dv/test_adc_control_registers.sv ----
// self-checking bench for the converter control block over its apb registers
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.svh"
module test_adc_control_registers;
    import adcc_pkg::*;
    // ==========================================================
    // design inputs, all given a value at time zero
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [4:0] paddr = 5'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [9:0] conv_data = 10'h000;
    logic [7:0] trig_in = 8'h00;
    logic gie = 1'b0;
    logic irq_ack = 1'b0;
    // design outputs
    logic [31:0] prdata;
    logic pready, pslverr, conv_on, conv_busy, gain_20x, diff_mode, temp_sensor_on;
    logic ref_settled, irq;
    adcc_ref_type ref_sel_eff;
    logic [3:0] chan_eff;
    int errors = 0;
    int compares = 0;
    // short settling so the reference wait stays a few cycles long
    localparam int SETTLE = 20;
    localparam logic [7:0] EN = 8'h01 << `ADCC_CSRA_EN;
    localparam logic [7:0] ST = 8'h01 << `ADCC_CSRA_START;
    localparam logic [7:0] AU = 8'h01 << `ADCC_CSRA_AUTO;
    localparam logic [7:0] FL = 8'h01 << `ADCC_CSRA_FLAG;
    localparam logic [7:0] IE = 8'h01 << `ADCC_CSRA_IE;
    localparam logic [7:0] AL = 8'h01 << `ADCC_MUX_ALIGN;

    // free-running 100 MHz clock
    always #5 mclk = ~mclk;

    adcc_top #(.SETTLE_CYCLES(SETTLE)) adcc_top_inst (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_data(conv_data), .conv_on(conv_on),
        .conv_busy(conv_busy), .ref_sel_eff(ref_sel_eff), .chan_eff(chan_eff),
        .gain_20x(gain_20x), .diff_mode(diff_mode), .temp_sensor_on(temp_sensor_on),
        .ref_settled(ref_settled), .trig_in(trig_in), .gie(gie), .irq_ack(irq_ack),
        .irq(irq)
    );

    // ==========================================================
    // checking and bus tasks
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task apb(input logic wr, input logic [2:0] idx, input logic [7:0] d,
             output logic [7:0] q, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [2:0] idx, input logic [7:0] d);
        logic [7:0] q;
        logic e;
        apb(1'b1, idx, d, q, e);
    endtask

    task rd(input logic [2:0] idx, output logic [7:0] q);
        logic e;
        apb(1'b0, idx, 8'h00, q, e);
    endtask

    // counts the busy cycles of the next conversion
    task conv(output int n);
        n = 0;
        for (int k = 0; k < 8000; k++) begin
            @(posedge mclk);
            if (conv_busy === 1'b1) n++;
            else if (n > 0) break;
        end
    endtask

    // the prescaler runs free, so the first tick may come up to one period early
    function automatic logic win(input int n, input int t, input int f);
        return (n > (t - 1) * f) && (n <= t * f + 2);
    endfunction

    task report_and_stop;
        $display("counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog: the tests need about 10500 cycles
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        report_and_stop;
    end

    // ==========================================================
    // test sequence
    initial begin
        logic [7:0] q;
        logic e;
        int n;
        int f;
        logic [2:0] r;
        adcc_ref_type er;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        // reset values, then unmapped read and write are refused
        rd(`ADCC_IDX_CSRA, q);
        chk(q, 8'h00);
        rd(`ADCC_IDX_MUX, q);
        chk(q, 8'h00);
        rd(`ADCC_IDX_RES_HI, q);
        chk(q, 8'h00);
        apb(1'b0, 3'h0, 8'h00, q, e);
        chk({e, q}, 9'h100);
        apb(1'b1, 3'h1, 8'hff, q, e);
        chk(e, 1'b1);
        $display("test reset done");
        // every divider code, first conversion long, next one short
        for (int c = 0; c < 8; c++) begin
            f = (c < 2) ? 2 : (1 << c);
            wr(`ADCC_IDX_CSRA, 8'h00);
            wr(`ADCC_IDX_CSRA, EN | ST | 8'(c));
            conv(n);
            chk(win(n, 25, f), 1'b1);
            wr(`ADCC_IDX_CSRA, EN | ST | FL | 8'(c));
            conv(n);
            chk(win(n, 13, f), 1'b1);
        end
        $display("test lengths done");
        // busy readback, zero write ignored, flag and both alignments
        conv_data <= 10'h2d5;
        wr(`ADCC_IDX_CSRA, EN | ST | FL);
        rd(`ADCC_IDX_CSRA, q);
        chk(q[6], 1'b1);
        wr(`ADCC_IDX_CSRA, EN);
        chk(conv_busy, 1'b1);
        conv(n);
        rd(`ADCC_IDX_CSRA, q);
        chk(q & 8'h50, 8'h10);
        rd(`ADCC_IDX_RES_LO, q);
        chk(q, 8'hd5);
        rd(`ADCC_IDX_RES_HI, q);
        chk(q, 8'h02);
        wr(`ADCC_IDX_MUX, AL);
        rd(`ADCC_IDX_RES_LO, q);
        chk(q, 8'h40);
        rd(`ADCC_IDX_RES_HI, q);
        chk(q, 8'hb5);
        // a low-byte read holds the pair against the next completion
        rd(`ADCC_IDX_RES_LO, q);
        conv_data <= 10'h13a;
        wr(`ADCC_IDX_CSRA, EN | ST | FL);
        conv(n);
        rd(`ADCC_IDX_RES_HI, q);
        chk(q, 8'hb5);
        wr(`ADCC_IDX_CSRA, EN | ST | FL);
        conv(n);
        rd(`ADCC_IDX_RES_HI, q);
        chk(q, 8'h4e);
        $display("test result done");
        // selection changed mid-conversion waits for completion, then a long one
        wr(`ADCC_IDX_CSRA, EN | ST | FL);
        wr(`ADCC_IDX_MUX, 8'h87);
        chk({ref_sel_eff, chan_eff}, {ADCC_REF_SUPPLY, 4'h0});
        conv(n);
        @(posedge mclk);
        chk({ref_sel_eff, diff_mode, gain_20x, chan_eff}, {ADCC_REF_1V1, 6'h37});
        wr(`ADCC_IDX_CSRA, EN | ST | FL);
        conv(n);
        chk(win(n, 25, 2), 1'b1);
        // internal reference settling
        wr(`ADCC_IDX_MUX, 8'h00);
        repeat (2) @(posedge mclk);
        chk(ref_settled, 1'b0);
        wr(`ADCC_IDX_MUX, 8'h80);
        repeat (2) @(posedge mclk);
        chk(ref_settled, 1'b0);
        repeat (SETTLE + 5) @(posedge mclk);
        chk(ref_settled, 1'b1);
        rd(`ADCC_IDX_TRIG, q);
        chk(q[`ADCC_TRIG_SETTLED], 1'b1);
        $display("test settle done");
        // every reference code and every channel code while idle
        for (int i = 0; i < 16; i++) begin
            r = 3'(i);
            wr(`ADCC_IDX_MUX, {r[1], r[0], 1'b0, r[2], 4'(i)});
            repeat (2) @(posedge mclk);
            case (r)
                3'h0, 3'h4: er = ADCC_REF_SUPPLY;
                3'h1, 3'h5: er = ADCC_REF_EXT;
                3'h2: er = ADCC_REF_1V1;
                3'h3: er = ADCC_REF_RSVD;
                3'h6: er = ADCC_REF_2V56;
                default: er = ADCC_REF_2V56_CAP;
            endcase
            chk(ref_sel_eff, er);
            chk({temp_sensor_on, diff_mode, gain_20x, chan_eff},
                {i == 15, i > 3 && i < 12, i > 3 && i < 12 && i[0] == 1, 4'(i)});
        end
        $display("test select done");
        // free running with interrupt, acknowledge clears it
        gie <= 1'b1;
        wr(`ADCC_IDX_TRIG, 8'h00);
        wr(`ADCC_IDX_CSRA, EN | AU | ST | IE | FL);
        for (int k = 0; k < 200; k++) begin
            @(posedge mclk);
            if (irq === 1'b1) break;
        end
        chk(irq, 1'b1);
        repeat (3) @(posedge mclk);
        chk(conv_busy, 1'b1);
        irq_ack <= 1'b1;
        @(posedge mclk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        wr(`ADCC_IDX_CSRA, EN | FL);
        conv(n);
        repeat (40) @(posedge mclk);
        chk(conv_busy, 1'b0);
        // auto trigger on a rising edge only
        wr(`ADCC_IDX_TRIG, 8'h03);
        wr(`ADCC_IDX_CSRA, EN | AU | FL);
        chk(conv_busy, 1'b0);
        trig_in <= 8'h08;
        repeat (3) @(posedge mclk);
        chk(conv_busy, 1'b1);
        conv(n);
        repeat (40) @(posedge mclk);
        chk(conv_busy, 1'b0);
        trig_in <= 8'h00;
        // interrupt gating by the global enable, then write-one clear
        wr(`ADCC_IDX_CSRA, EN | IE);
        gie <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        gie <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(irq, 1'b1);
        wr(`ADCC_IDX_CSRA, EN | IE | FL);
        rd(`ADCC_IDX_CSRA, q);
        chk({irq, q[4]}, 2'b00);
        $display("test auto and interrupt done");
        // disabling mid-conversion aborts without a flag
        wr(`ADCC_IDX_CSRA, EN | ST);
        wr(`ADCC_IDX_CSRA, 8'h00);
        repeat (60) @(posedge mclk);
        chk({conv_busy, conv_on}, 2'b00);
        rd(`ADCC_IDX_CSRA, q);
        chk(q, 8'h00);
        $display("test abort done");
        report_and_stop;
    end
endmodule
`default_nettype wire
